// *** sock_irq_pkg.sv ***
// Package for the socket status-change interrupt and window-enable block.
// Assumes an AXI4-Lite register bus with 32-bit data.
package sock_irq_pkg;

    // Register indices (printed offsets are not all multiples of four)
    localparam logic [7:0] IDX_STATUS_CHANGE  = 8'h04;
    localparam logic [7:0] IDX_MGMT_IRQ_CFG   = 8'h05;
    localparam logic [7:0] IDX_WINDOW_ENABLE  = 8'h06;
    localparam logic [7:0] IDX_DEDICATED_IRQ_LINE_CONTROL   = 8'h03;
    localparam logic [7:0] IDX_SYS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] IDX_SYS_IRQ_MASK   = 8'h11;

    localparam int ADDR_W = 8;

    // Reset values
    localparam logic [7:0] MGMT_IRQ_CFG_RST  = 8'h00;
    localparam logic [7:0] WINDOW_ENABLE_RST = 8'h00;
    localparam logic [7:0] DEDICATED_IRQ_LINE_CONTROL_RST  = 8'h00;
    localparam logic [3:0] SYS_IRQ_MASK_RST  = 4'h0;

    // Field positions
    localparam int BIT_BATT_DEAD   = 0;
    localparam int BIT_BATT_WARN   = 1;
    localparam int BIT_READY       = 2;
    localparam int BIT_CARD_DETECT = 3;
    localparam int SEL_LSB         = 4;
    localparam int BIT_REDIRECT    = 4;
    localparam int BIT_CARD_IS_IO  = 5;
    localparam int BIT_FULL_DECODE = 5;
    localparam int BIT_IO_WIN0     = 6;
    localparam int NUM_MEM_WIN     = 5;
    localparam int NUM_IO_WIN      = 2;
    localparam int NUM_IRQ_PINS    = 16;

    // Routing codes
    localparam logic [3:0] SEL_DISABLED = 4'h0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // Synchronised socket pins
    typedef struct packed {
        logic card_detect_a;
        logic card_detect_b;
        logic battery_dead;
        logic battery_warning;
        logic ready;
    } socket_pins_t;

    // Window enables
    typedef struct packed {
        logic [NUM_IO_WIN-1:0]  io_en;
        logic [NUM_MEM_WIN-1:0] mem_en;
    } window_en_t;

endpackage

// *** edge_sync.sv ***
// Two-stage synchroniser with change detectors for one socket pin.
// Assumes an asynchronous pin and a single clock.
`timescale 1ns/1ps
module edge_sync (
    input  wire logic clk_in,
    input  wire logic rst_in,
    input  wire logic pin_in,
    output logic      level_out,
    output logic      any_edge_out,
    output logic      fall_out
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    // Change seen from one clock after reset release, while prev_reg may still hold its reset value
    logic primed_reg;
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            primed_reg <= 1'b0;
        end else begin
            primed_reg <= 1'b1;
        end
    end

    assign level_out    = sync_reg;
    assign any_edge_out = primed_reg && (sync_reg != prev_reg);
    assign fall_out     = primed_reg && prev_reg && !sync_reg;
endmodule

// *** sock_irq.sv ***
// Socket status-change flags, management interrupt routing and window enables.
// Assumes an AXI4-Lite master on clk_in and asynchronous socket pins.
// How it works
// - Either card-detect pin changing sets the card-detect change flag.
// - Any read of the status-change register clears its flags.
// - Bit 0 enable gates battery-dead/status change onto the management interrupt.
// - Bit 1 enable gates battery-warning change; ignored in I/O card mode.
// - Bit 2 enable gates ready change onto the management interrupt.
// - Bit 3 enable gates card-detect change onto the management interrupt.
// - Bits 7:4 pick the IRQ pin; 0000 routes nowhere.
// - Pins 9, 10, 12, 15 may have alternate roles outside this block.
// - Enable bits 0-4 switch the five memory windows on.
// - Bits 6 and 7 switch I/O windows 0 and 1 on.
// - Bit 5 of window enable has no effect; full decode always.
// - Redirect bit sends management interrupts to the dedicated line.
// - Battery-dead flag: falling edge in memory mode, either edge in I/O.
// - Ready flag sets on ready changes; reads zero in I/O mode.
`timescale 1ns/1ps
module sock_irq (
    input  wire logic                          clk_in,
    input  wire logic                          rst_in,
    // AXI4-Lite slave
    input  wire logic [sock_irq_pkg::ADDR_W+1:0] s_axi_awaddr_in,
    input  wire logic                          s_axi_awvalid_in,
    output logic                               s_axi_awready_out,
    input  wire logic [31:0]                   s_axi_wdata_in,
    input  wire logic [3:0]                    s_axi_wstrb_in,
    input  wire logic                          s_axi_wvalid_in,
    output logic                               s_axi_wready_out,
    output logic [1:0]                         s_axi_bresp_out,
    output logic                               s_axi_bvalid_out,
    input  wire logic                          s_axi_bready_in,
    input  wire logic [sock_irq_pkg::ADDR_W+1:0] s_axi_araddr_in,
    input  wire logic                          s_axi_arvalid_in,
    output logic                               s_axi_arready_out,
    output logic [31:0]                        s_axi_rdata_out,
    output logic [1:0]                         s_axi_rresp_out,
    output logic                               s_axi_rvalid_out,
    input  wire logic                          s_axi_rready_in,
    // Socket pins
    input  wire logic                          card_detect_in_a,
    input  wire logic                          card_detect_in_b,
    input  wire logic                          battery_dead_status_in,
    input  wire logic                          battery_warning_in,
    input  wire logic                          card_ready_irq_in,
    // Host interrupt pins and window enables
    output logic [15:0]                        host_irq_out,
    output logic                               dedicated_irq_line_out,
    output sock_irq_pkg::window_en_t           window_en_out,
    output logic                               sys_irq_out
);
    import sock_irq_pkg::*;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    socket_pins_t pin_raw;
    socket_pins_t pin_any;
    socket_pins_t pin_fall;

    assign pin_raw = '{card_detect_a:   card_detect_in_a,
                       card_detect_b:   card_detect_in_b,
                       battery_dead:    battery_dead_status_in,
                       battery_warning: battery_warning_in,
                       ready:           card_ready_irq_in};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++) begin : g_sync
            edge_sync u_sync (
                .clk_in       (clk_in),
                .rst_in       (rst_in),
                .pin_in       (pin_raw[gi]),
                .level_out    (),
                .any_edge_out (pin_any[gi]),
                .fall_out     (pin_fall[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mgmt_cfg_reg;
    logic [7:0] win_en_reg;
    logic [7:0] dedicated_irq_line_ctl_reg;
    logic [3:0] change_reg;
    logic [3:0] sys_status_reg;
    logic [3:0] sys_mask_reg;

    logic       card_is_io;
    assign card_is_io = dedicated_irq_line_ctl_reg[BIT_CARD_IS_IO];

    // ------------------------------------------------------------
    // AXI write path
    // ------------------------------------------------------------
    logic                aw_held_reg;
    logic                w_held_reg;
    logic [ADDR_W-1:0]   aw_idx_reg;
    logic [31:0]         wdata_reg;
    logic [3:0]          wstrb_reg;

    wire aw_take   = s_axi_awvalid_in && s_axi_awready_out;
    wire w_take    = s_axi_wvalid_in && s_axi_wready_out;
    wire wr_do     = aw_held_reg && w_held_reg && !s_axi_bvalid_out;
    wire wr_lane0  = wr_do && wstrb_reg[0];
    wire wr_cfg    = wr_lane0 && (aw_idx_reg == IDX_MGMT_IRQ_CFG);
    wire wr_win    = wr_lane0 && (aw_idx_reg == IDX_WINDOW_ENABLE);
    wire wr_ctl    = wr_lane0 && (aw_idx_reg == IDX_DEDICATED_IRQ_LINE_CONTROL);
    wire wr_sstat  = wr_lane0 && (aw_idx_reg == IDX_SYS_IRQ_STATUS);
    wire wr_smask  = wr_lane0 && (aw_idx_reg == IDX_SYS_IRQ_MASK);
    wire wr_hit    = (aw_idx_reg == IDX_MGMT_IRQ_CFG) || (aw_idx_reg == IDX_WINDOW_ENABLE)
                  || (aw_idx_reg == IDX_DEDICATED_IRQ_LINE_CONTROL) || (aw_idx_reg == IDX_SYS_IRQ_STATUS)
                  || (aw_idx_reg == IDX_SYS_IRQ_MASK) || (aw_idx_reg == IDX_STATUS_CHANGE);

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_reg       <= 1'b0;
            w_held_reg        <= 1'b0;
            aw_idx_reg        <= '0;
            wdata_reg         <= 32'h0000_0000;
            wstrb_reg         <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= RESP_OKAY;
        end else begin
            s_axi_awready_out <= !aw_held_reg && !aw_take;
            s_axi_wready_out  <= !w_held_reg && !w_take;
            if (aw_take) begin
                aw_held_reg <= 1'b1;
                aw_idx_reg  <= s_axi_awaddr_in[ADDR_W+1:2];
            end
            if (w_take) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata_in;
                wstrb_reg  <= s_axi_wstrb_in;
            end
            if (wr_do) begin
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
                aw_held_reg      <= 1'b0;
                w_held_reg       <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // AXI read path
    // ------------------------------------------------------------
    wire ar_take = s_axi_arvalid_in && s_axi_arready_out;
    wire [ADDR_W-1:0] ar_idx = s_axi_araddr_in[ADDR_W+1:2];
    wire rd_status = ar_take && (ar_idx == IDX_STATUS_CHANGE);

    logic [7:0] change_view;
    assign change_view = {4'h0, change_reg[BIT_CARD_DETECT],
                          change_reg[BIT_READY] && !card_is_io,
                          change_reg[BIT_BATT_WARN], change_reg[BIT_BATT_DEAD]};

    logic [31:0] rd_word;
    logic        rd_hit;
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (ar_idx)
            IDX_STATUS_CHANGE:  rd_word[7:0] = change_view;
            IDX_MGMT_IRQ_CFG:   rd_word[7:0] = mgmt_cfg_reg;
            IDX_WINDOW_ENABLE:  rd_word[7:0] = win_en_reg;
            IDX_DEDICATED_IRQ_LINE_CONTROL:   rd_word[7:0] = dedicated_irq_line_ctl_reg;
            IDX_SYS_IRQ_STATUS: rd_word[3:0] = sys_status_reg;
            IDX_SYS_IRQ_MASK:   rd_word[3:0] = sys_mask_reg;
            default:            rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= RESP_OKAY;
        end else begin
            s_axi_arready_out <= !s_axi_rvalid_out && !ar_take;
            if (ar_take) begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rdata_out  <= rd_word;
                s_axi_rresp_out  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mgmt_cfg_reg <= MGMT_IRQ_CFG_RST;
            win_en_reg   <= WINDOW_ENABLE_RST;
            dedicated_irq_line_ctl_reg <= DEDICATED_IRQ_LINE_CONTROL_RST;
            sys_mask_reg <= SYS_IRQ_MASK_RST;
        end else begin
            if (wr_cfg) mgmt_cfg_reg <= wdata_reg[7:0];
            if (wr_win) win_en_reg <= wdata_reg[7:0];
            if (wr_ctl) dedicated_irq_line_ctl_reg <= wdata_reg[7:0];
            if (wr_smask) sys_mask_reg <= wdata_reg[3:0];
        end
    end

    // ------------------------------------------------------------
    // Change flags
    // ------------------------------------------------------------
    logic [3:0] change_set;
    assign change_set[BIT_CARD_DETECT] = pin_any.card_detect_a || pin_any.card_detect_b;
    assign change_set[BIT_BATT_DEAD]   = card_is_io ? pin_any.battery_dead
                                                    : pin_fall.battery_dead;
    assign change_set[BIT_BATT_WARN]   = pin_fall.battery_warning;
    assign change_set[BIT_READY]       = pin_any.ready;

    logic [3:0] change_next;
    // Set wins over the read-clear in the same cycle
    assign change_next = (rd_status ? 4'h0 : change_reg) | change_set;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            change_reg <= 4'h0;
        end else begin
            change_reg <= change_next;
        end
    end

    // ------------------------------------------------------------
    // Management interrupt and routing
    // ------------------------------------------------------------
    logic [3:0] gated;
    assign gated[BIT_BATT_DEAD]   = change_reg[BIT_BATT_DEAD] && mgmt_cfg_reg[BIT_BATT_DEAD];
    assign gated[BIT_BATT_WARN]   = change_reg[BIT_BATT_WARN] && mgmt_cfg_reg[BIT_BATT_WARN]
                                    && !card_is_io;
    assign gated[BIT_READY]       = change_view[BIT_READY] && mgmt_cfg_reg[BIT_READY];
    assign gated[BIT_CARD_DETECT] = change_reg[BIT_CARD_DETECT] && mgmt_cfg_reg[BIT_CARD_DETECT];

    wire        mgmt_req = |gated;
    wire [3:0]  sel      = mgmt_cfg_reg[SEL_LSB+3:SEL_LSB];
    wire        redirect = dedicated_irq_line_ctl_reg[BIT_REDIRECT];

    // Pins with alternate roles (9, 10, 12, 15) are routed alike here
    localparam logic [15:0] VALID_PINS = 16'b1101_1110_1011_1000;

    logic [15:0] irq_decode;
    always_comb begin
        irq_decode = 16'h0000;
        if (mgmt_req && !redirect && sel != SEL_DISABLED) begin
            irq_decode[sel] = VALID_PINS[sel];
        end
    end

    // Sticky host-side events: management request rise, card detect change
    logic mgmt_req_prev_reg;
    logic [3:0] sys_set;
    assign sys_set = {2'b00, change_set[BIT_CARD_DETECT], mgmt_req && !mgmt_req_prev_reg};
    wire [3:0] sys_clr = wr_sstat ? wdata_reg[3:0] : 4'h0;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            host_irq_out           <= 16'h0000;
            dedicated_irq_line_out <= 1'b0;
            window_en_out          <= '0;
            sys_status_reg         <= 4'h0;
            mgmt_req_prev_reg      <= 1'b0;
            sys_irq_out            <= 1'b0;
        end else begin
            host_irq_out           <= irq_decode;
            dedicated_irq_line_out <= mgmt_req && redirect;
            // Full-decode bit never reaches the output
            window_en_out.mem_en   <= win_en_reg[NUM_MEM_WIN-1:0];
            window_en_out.io_en    <= win_en_reg[BIT_IO_WIN0+1:BIT_IO_WIN0];
            mgmt_req_prev_reg      <= mgmt_req;
            sys_status_reg         <= (sys_status_reg & ~sys_clr) | sys_set;
            sys_irq_out            <= |(sys_status_reg & sys_mask_reg);
        end
    end
endmodule

// *** sock_irq_props.sv ***
// Checker for the socket interrupt block, bound to its ports.
// Assumes one clock domain and an active-high asynchronous reset.
`timescale 1ns/1ps
module sock_irq_props (
    input wire logic [sock_irq_pkg::ADDR_W+1:0] s_axi_awaddr_in,
    input wire logic                            clk_in,
    input wire logic                            rst_in,
    input wire logic                            s_axi_awvalid_in,
    input wire logic                            s_axi_awready_out,
    input wire logic [31:0]                     s_axi_wdata_in,
    input wire logic [3:0]                      s_axi_wstrb_in,
    input wire logic                            s_axi_wvalid_in,
    input wire logic                            s_axi_wready_out,
    input wire logic                            s_axi_bvalid_out,
    input wire logic                            s_axi_arvalid_in,
    input wire logic                            s_axi_arready_out,
    input wire logic [31:0]                     s_axi_rdata_out,
    input wire logic                            s_axi_rvalid_out,
    input wire logic [15:0]                     host_irq_out,
    input wire logic                            dedicated_irq_line_out,
    input wire sock_irq_pkg::window_en_t        window_en_out
);
    import sock_irq_pkg::*;
    logic [7:0] wr_idx_reg;
    logic [7:0] wr_data_reg;
    logic       wr_strb_reg;
    // Last write address and data, for window enable checks
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_idx_reg  <= 8'h00;
            wr_data_reg <= 8'h00;
            wr_strb_reg <= 1'b0;
        end else begin
            if (s_axi_awvalid_in && s_axi_awready_out) wr_idx_reg <= s_axi_awaddr_in[9:2];
            if (s_axi_wvalid_in && s_axi_wready_out) wr_data_reg <= s_axi_wdata_in[7:0];
            if (s_axi_wvalid_in && s_axi_wready_out) wr_strb_reg <= s_axi_wstrb_in[0];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    ded_excl_a: assert property (
        dedicated_irq_line_out |-> host_irq_out == 16'h0000) else $error("pin and dedicated line both high");
    pin_onehot_a: assert property (
        $onehot0(host_irq_out)) else $error("more than one host pin high");
    reserved_pin_a: assert property (
        (host_irq_out & 16'h2147) == 16'h0000) else $error("reserved code drives a pin");
    win_change_a: assert property (
        !$stable(window_en_out) |-> $past(s_axi_bvalid_out) && !$past(s_axi_bvalid_out, 2))
        else $error("window enables moved without write");
    win_value_a: assert property (
        $rose(s_axi_bvalid_out) && wr_idx_reg == IDX_WINDOW_ENABLE && wr_strb_reg
        |=> window_en_out == {wr_data_reg[7:6], wr_data_reg[4:0]}) else $error("window enables wrong");
    rd_answer_a: assert property (
        s_axi_arvalid_in && s_axi_arready_out |-> ##[1:2] s_axi_rvalid_out) else $error("read not answered");
    wr_answer_a: assert property (
        s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
        |-> ##[1:2] s_axi_bvalid_out) else $error("write not answered");
    rdata_upper_a: assert property (
        s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000) else $error("upper read data not zero");
    cover property ($rose(dedicated_irq_line_out));
    cover property ($rose(|host_irq_out[15:9]));
    cover property ($rose(s_axi_bvalid_out) && wr_idx_reg == IDX_WINDOW_ENABLE);
endmodule

bind sock_irq sock_irq_props i_sock_irq_props (.clk_in, .rst_in, .s_axi_awaddr_in, .s_axi_awvalid_in,
    .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in, .s_axi_wvalid_in, .s_axi_wready_out,
    .s_axi_bvalid_out, .s_axi_arvalid_in, .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rvalid_out,
    .host_irq_out, .dedicated_irq_line_out, .window_en_out);

// *** card_model.sv ***
// Card side of the socket: drives the five status pins.
// Assumes the bench pulses toggle_in for one cycle per pin change.
`timescale 1ns/1ps
module card_model (
    input  wire logic                   clk_in,
    input  wire logic                   rst_in,
    input  wire logic [4:0]             toggle_in,
    output sock_irq_pkg::socket_pins_t  pins_out
);
    import sock_irq_pkg::*;
    // Pins are always driven by a seated card
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pins_out <= '0;
        end else begin
            pins_out <= socket_pins_t'(pins_out ^ toggle_in);
        end
    end
endmodule

// *** tb_sock_irq.sv ***
// Bench for the socket interrupt block: register bus and pin events.
// Assumes the checker is bound in and the card model drives the pins.
`timescale 1ns/1ps
module tb_sock_irq;
    import sock_irq_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [9:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, ded, sys_irq;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] host_irq;
    logic [4:0] tog = '0;
    socket_pins_t pins;
    window_en_t win;
    int err_count = 0;
    int compares = 0;

    card_model i_card_model (.clk_in(clk_in), .rst_in(rst_in), .toggle_in(tog), .pins_out(pins));
    sock_irq i_sock_irq (.clk_in(clk_in), .rst_in(rst_in),
        .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
        .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
        .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
        .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
        .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
        .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
        .card_detect_in_a(pins.card_detect_a), .card_detect_in_b(pins.card_detect_b),
        .battery_dead_status_in(pins.battery_dead), .battery_warning_in(pins.battery_warning),
        .card_ready_irq_in(pins.ready), .host_irq_out(host_irq), .dedicated_irq_line_out(ded),
        .window_en_out(win), .sys_irq_out(sys_irq));

    initial forever #2 clk_in = ~clk_in;

    task automatic final_report();
        if (err_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
        int n;
        @(posedge clk_in);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 100);
        bready <= 1'b0;
        chk("bvalid", 32'h1, 32'(bvalid));
        chk("bresp", 32'(er), 32'(bresp));
    endtask

    task automatic rd(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e, input logic [1:0] er);
        int n;
        @(posedge clk_in);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 100);
        rready <= 1'b0;
        chk("rvalid", 32'h1, 32'(rvalid));
        chk("rdata", e & m, rdata & m);
        chk("rresp", 32'(er), 32'(rresp));
    endtask

    // One pin change, then the pins, the flags and the clear
    task automatic ev(input logic [4:0] t, input logic [15:0] h, input logic d, input logic [7:0] f,
                      input logic [7:0] m);
        @(posedge clk_in);
        tog <= t;
        @(posedge clk_in);
        tog <= 5'h00;
        repeat (8) @(posedge clk_in);
        chk("host_irq", 32'(h), 32'(host_irq));
        chk("dedicated", 32'(d), 32'(ded));
        rd(IDX_STATUS_CHANGE, {24'h0, m}, {24'h0, f}, RESP_OKAY);
        repeat (3) @(posedge clk_in);
        chk("host_irq_clr", 32'h0, 32'(host_irq));
        chk("dedicated_clr", 32'h0, 32'(ded));
    endtask

    function automatic logic [15:0] pin_of(input logic [3:0] c);
        if (c inside {4'h0, 4'h1, 4'h2, 4'h6, 4'h8, 4'hD}) return 16'h0000;
        return 16'h0001 << c;
    endfunction

    initial begin
        repeat (50000) @(posedge clk_in);
        err_count++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk_in);
        rst_in <= 1'b0;
        rd(IDX_MGMT_IRQ_CFG, 32'hFF, {24'h0, MGMT_IRQ_CFG_RST}, RESP_OKAY);
        rd(IDX_WINDOW_ENABLE, 32'hFF, {24'h0, WINDOW_ENABLE_RST}, RESP_OKAY);
        rd(IDX_SYS_IRQ_MASK, 32'hF, {28'h0, SYS_IRQ_MASK_RST}, RESP_OKAY);
        rd(8'h20, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
        wr(8'h20, 8'hFF, RESP_SLVERR);
        wr(IDX_WINDOW_ENABLE, 8'hFF, RESP_OKAY);
        @(posedge clk_in);
        chk("window_en", 32'h7F, 32'(win));
        rd(IDX_WINDOW_ENABLE, 32'hFF, 32'hFF, RESP_OKAY);
        wr(IDX_WINDOW_ENABLE, 8'h20, RESP_OKAY);
        @(posedge clk_in);
        chk("window_en", 32'h00, 32'(win));
        wr(IDX_WINDOW_ENABLE, 8'h41, RESP_OKAY);
        @(posedge clk_in);
        chk("window_en", 32'h21, 32'(win));
        for (int c = 0; c < 16; c++) begin
            wr(IDX_MGMT_IRQ_CFG, {c[3:0], 4'h8}, RESP_OKAY);
            ev(c[0] ? 5'h10 : 5'h08, pin_of(c[3:0]), 1'b0, 8'h08, 8'hFF);
        end
        wr(IDX_MGMT_IRQ_CFG, 8'h30, RESP_OKAY);
        ev(5'h10, 16'h0000, 1'b0, 8'h08, 8'hFF);
        wr(IDX_MGMT_IRQ_CFG, 8'h31, RESP_OKAY);
        ev(5'h04, 16'h0000, 1'b0, 8'h00, 8'h01);
        ev(5'h04, 16'h0008, 1'b0, 8'h01, 8'h01);
        wr(IDX_MGMT_IRQ_CFG, 8'h32, RESP_OKAY);
        ev(5'h02, 16'h0000, 1'b0, 8'h00, 8'h02);
        ev(5'h02, 16'h0008, 1'b0, 8'h02, 8'h02);
        wr(IDX_MGMT_IRQ_CFG, 8'h34, RESP_OKAY);
        ev(5'h01, 16'h0008, 1'b0, 8'h04, 8'h04);
        wr(IDX_MGMT_IRQ_CFG, 8'h30, RESP_OKAY);
        ev(5'h01, 16'h0000, 1'b0, 8'h04, 8'h04);
        chk("sys_irq", 32'h0, 32'(sys_irq));
        wr(IDX_SYS_IRQ_MASK, 8'h03, RESP_OKAY);
        repeat (2) @(posedge clk_in);
        chk("sys_irq", 32'h1, 32'(sys_irq));
        wr(IDX_SYS_IRQ_STATUS, 8'h03, RESP_OKAY);
        repeat (2) @(posedge clk_in);
        chk("sys_irq", 32'h0, 32'(sys_irq));
        wr(IDX_MGMT_IRQ_CFG, 8'h3F, RESP_OKAY);
        wr(IDX_DEDICATED_IRQ_LINE_CONTROL, 8'h20, RESP_OKAY);
        ev(5'h04, 16'h0008, 1'b0, 8'h01, 8'h01);
        ev(5'h02, 16'h0000, 1'b0, 8'h00, 8'h02);
        ev(5'h02, 16'h0000, 1'b0, 8'h02, 8'h02);
        ev(5'h01, 16'h0000, 1'b0, 8'h00, 8'h04);
        wr(IDX_DEDICATED_IRQ_LINE_CONTROL, 8'h10, RESP_OKAY);
        ev(5'h10, 16'h0000, 1'b1, 8'h08, 8'hFF);
        final_report();
    end
endmodule
